// *** hw/clock_status_control_pins.sv ***
// Pin control, status outputs and register file of the clock generator
//
// The implementer's own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R01: Disable pin high forces every clock output off.
// R02: Lock indicator high while locked, else low.
// R03: Each reference input has low-active loss flag.
// R04: Crystal loss flag low while crystal absent.
// R05: Step-up edge adds step size to target.
// R06: Step-down edge subtracts step size from target.
// R07: Target output and step size come from registers.
// R08: Manual mode takes reference from select pins.
// R09: Select code n picks reference input n.
// R10: One step per synchronised rising edge only.
module clock_status_control_pins
  import clock_status_control_pkg::*;
#(
  parameter int unsigned NUM_OUT = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic output_disable_n_i,
  input wire logic freq_step_up_i,
  input wire logic freq_step_down_i,
  input wire logic [1:0] input_select_i,
  input wire logic pll_locked_i,
  input wire logic [3:0] ref_clock_present_i,
  input wire logic xtal_present_i,
  output logic [NUM_OUT-1:0] clk_out_enable_o,
  output logic [NUM_OUT-1:0][31:0] freq_offset_o,
  output logic [1:0] active_ref_sel_o,
  output logic lock_indicator_n_o,
  output logic input0_signal_loss_n_o,
  output logic input1_signal_loss_n_o,
  output logic input2_signal_loss_n_o,
  output logic input3_signal_loss_n_o,
  output logic xtal_signal_loss_n_o,
  output logic irq_o
);

  // Synchroniser stages, first stage read only by the second
  pin_t pin_s1_q;
  pin_t pin_s2_q;
  monitor_t mon_s1_q;
  monitor_t mon_s2_q;
  // Previous values for edge and event detection
  pin_t pin_prev_q;
  monitor_t mon_prev_q;
  // Register file
  logic [2:0] ctrl_q;
  logic [NUM_OUT-1:0] out_en_q;
  logic [31:0] step_size_q;
  logic [TGT_W-1:0] step_tgt_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_en_q;
  // Bus handshake
  logic ack_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic access;
  logic wr;
  logic [7:0] adr;
  logic [31:0] wmask;
  // Frequency offsets, one per output
  logic [NUM_OUT-1:0][31:0] offset_q;
  logic [31:0] tgt_offset;
  logic tgt_valid;
  // Step edges and events
  logic up_rise;
  logic down_rise;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] irq_clr;
  // Status output registers
  logic [NUM_OUT-1:0] clk_en_q;
  logic [1:0] active_ref_q;
  logic lock_q;
  logic [3:0] loss_n_q;
  logic xtal_n_q;

  // Two-flop synchronisers for all pins and monitor levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      mon_s1_q <= '0;
      mon_s2_q <= '0;
    end else begin
      pin_s1_q <= '{output_disable_n_i, freq_step_up_i, freq_step_down_i, input_select_i};
      pin_s2_q <= pin_s1_q;
      mon_s1_q <= '{pll_locked_i, ref_clock_present_i, xtal_present_i};
      mon_s2_q <= mon_s1_q;
    end
  end

  // History for edge detection, fed only from stage two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_prev_q <= '0;
      mon_prev_q <= '0;
    end else begin
      pin_prev_q <= pin_s2_q;
      mon_prev_q <= mon_s2_q;
    end
  end

  // A held pin gives one step; a new step needs a low phase first
  assign up_rise = pin_s2_q.step_up && !pin_prev_q.step_up; // R10
  assign down_rise = pin_s2_q.step_down && !pin_prev_q.step_down; // R10

  // Bus decode; every byte address answers, the low two bits are ignored and unmapped words read zero
  assign access = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = access && wb_we_i;
  assign adr = {wb_adr_i[7:2], 2'b00};
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Classic slave: one wait state, ack stands for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= access;
      rdata_q <= access ? rdata_d : 32'h0000_0000;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // Control register: manual pin mode and software reference select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (wr && adr == CTRL_OFS) begin
      ctrl_q <= (ctrl_q & ~wmask[2:0]) | (wb_dat_i[2:0] & wmask[2:0]);
    end
  end

  // Configured per-output enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_en_q <= OUT_EN_RST[NUM_OUT-1:0];
    end else if (wr && adr == OUT_EN_OFS) begin
      out_en_q <= (out_en_q & ~wmask[NUM_OUT-1:0]) | (wb_dat_i[NUM_OUT-1:0] & wmask[NUM_OUT-1:0]);
    end
  end

  // Step size and step target are software set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_size_q <= STEP_SIZE_RST;
      step_tgt_q <= STEP_TGT_RST;
    end else if (wr && adr == STEP_SIZE_OFS) begin
      step_size_q <= (step_size_q & ~wmask) | (wb_dat_i & wmask); // R07
    end else if (wr && adr == STEP_TGT_OFS) begin
      step_tgt_q <= (step_tgt_q & ~wmask[3:0]) | (wb_dat_i[3:0] & wmask[3:0]); // R07
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_q <= IRQ_EN_RST;
    end else if (wr && adr == IRQ_EN_OFS) begin
      irq_en_q <= (irq_en_q & ~wmask[6:0]) | (wb_dat_i[6:0] & wmask[6:0]);
    end
  end

  // Events: lock change, reference loss, crystal loss, step pin edge
  assign events[IRQ_LOCK_BIT] = mon_s2_q.locked ^ mon_prev_q.locked;
  assign events[IRQ_XTAL_BIT:IRQ_REF_LSB] = {mon_prev_q.xtal_ok & ~mon_s2_q.xtal_ok,
                                             mon_prev_q.ref_ok & ~mon_s2_q.ref_ok};
  assign events[IRQ_STEP_BIT] = up_rise || down_rise;
  assign irq_clr = (wr && adr == IRQ_CLR_OFS) ? (wb_dat_i[6:0] & wmask[6:0]) : 7'h00;

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= 7'h00;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | events;
    end
  end
  assign irq_o = |(irq_stat_q & irq_en_q);

  // Offset of the targeted output, zero when the target is absent
  assign tgt_valid = step_tgt_q < TGT_W'(NUM_OUT);
  assign tgt_offset = tgt_valid ? offset_q[step_tgt_q] : 32'h0000_0000;

  // Register read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (adr)
      CTRL_OFS: rdata_d[2:0] = ctrl_q;
      OUT_EN_OFS: rdata_d[NUM_OUT-1:0] = out_en_q;
      STEP_SIZE_OFS: rdata_d = step_size_q;
      STEP_TGT_OFS: rdata_d[3:0] = step_tgt_q;
      STATUS_OFS: rdata_d[7:0] = {active_ref_q, mon_s2_q};
      IRQ_STAT_OFS: rdata_d[6:0] = irq_stat_q;
      IRQ_EN_OFS: rdata_d[6:0] = irq_en_q;
      OFFSET_OFS: rdata_d = tgt_offset;
      default: rdata_d = 32'h0000_0000; // Clear register and holes read zero
    endcase
  end

  // Per-output offset; opposite edges in one cycle cancel out
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        offset_q[g] <= 32'h0000_0000;
      end else if (step_tgt_q == TGT_W'(g)) begin // R07
        if (up_rise && !down_rise) begin
          offset_q[g] <= offset_q[g] + step_size_q; // R05
        end else if (down_rise && !up_rise) begin
          offset_q[g] <= offset_q[g] - step_size_q; // R06
        end
      end
    end
  end
  assign freq_offset_o = offset_q;

  // Output gating; outputs stay off through reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_en_q <= '0;
    end else if (pin_s2_q.out_off) begin
      clk_en_q <= '0; // R01
    end else begin
      clk_en_q <= out_en_q; // R01
    end
  end
  assign clk_out_enable_o = clk_en_q;

  // Active reference: pins in manual mode, register otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_ref_q <= 2'h0;
    end else if (ctrl_q[CTRL_MANUAL_BIT]) begin
      active_ref_q <= pin_s2_q.sel; // R08 R09
    end else begin
      active_ref_q <= ctrl_q[CTRL_SEL_LSB+1:CTRL_SEL_LSB];
    end
  end
  assign active_ref_sel_o = active_ref_q;

  // Status pins; reset shows unlocked and all signals lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_q <= 1'b0;
      loss_n_q <= 4'h0;
      xtal_n_q <= 1'b0;
    end else begin
      lock_q <= mon_s2_q.locked; // R02
      loss_n_q <= mon_s2_q.ref_ok; // R03
      xtal_n_q <= mon_s2_q.xtal_ok; // R04
    end
  end
  assign lock_indicator_n_o = lock_q;
  assign input0_signal_loss_n_o = loss_n_q[0];
  assign input1_signal_loss_n_o = loss_n_q[1];
  assign input2_signal_loss_n_o = loss_n_q[2];
  assign input3_signal_loss_n_o = loss_n_q[3];
  assign xtal_signal_loss_n_o = xtal_n_q;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_outputs_disabled: assert property ( // R01
    pin_s2_q.out_off |=> clk_out_enable_o == '0)
    else $error("outputs not disabled");
  // The release edge still loads the reset value, so it starts no attempt
  chk_outputs_follow: assert property ( // R01
    (!rst_i && !pin_s2_q.out_off) |=> clk_out_enable_o == $past(out_en_q))
    else $error("outputs not following enables");
  chk_lock_pin: assert property ( // R02
    !rst_i |=> lock_indicator_n_o == $past(mon_s2_q.locked))
    else $error("lock pin wrong");
  chk_ref_loss_pins: assert property ( // R03
    !rst_i |=> loss_n_q == $past(mon_s2_q.ref_ok))
    else $error("reference loss pins wrong");
  chk_xtal_loss_pin: assert property ( // R04
    !rst_i |=> xtal_signal_loss_n_o == $past(mon_s2_q.xtal_ok))
    else $error("crystal loss pin wrong");
  chk_step_up_add: assert property ( // R05
    (up_rise && !down_rise && tgt_valid && $stable(step_tgt_q)) |=>
      tgt_offset == $past(tgt_offset) + $past(step_size_q))
    else $error("step up wrong");
  chk_step_down_sub: assert property ( // R06
    (down_rise && !up_rise && tgt_valid && $stable(step_tgt_q)) |=>
      tgt_offset == $past(tgt_offset) - $past(step_size_q))
    else $error("step down wrong");
  chk_idle_no_step: assert property ( // R10
    (!rst_i && !up_rise && !down_rise) |=> $stable(freq_offset_o))
    else $error("offset moved without edge");
  // Stage one stays private to stage two, so the check looks at the edge only
  chk_held_pin_once: assert property ( // R10
    up_rise |=> !up_rise)
    else $error("held pin stepped twice");
  chk_manual_select: assert property ( // R08
    ctrl_q[CTRL_MANUAL_BIT] |=> active_ref_sel_o == $past(pin_s2_q.sel))
    else $error("manual select wrong");
  chk_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");

  cov_step_up: cover property (up_rise ##[1:100] up_rise);
  cov_step_down: cover property (down_rise);
  cov_disable: cover property (pin_s2_q.out_off ##1 !pin_s2_q.out_off);
  cov_irq_lock: cover property (irq_o && irq_stat_q[IRQ_LOCK_BIT]);

endmodule

`default_nettype wire

// *** hw/clock_status_control_pkg.sv ***
// Constants and carrier types for the clock status and control pin logic
package clock_status_control_pkg;
  // Bus and register geometry
  localparam int unsigned ADR_W = 8;
  localparam int unsigned TGT_W = 4;
  localparam int unsigned IRQ_W = 7;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] OUT_EN_OFS = 8'h04;
  localparam logic [7:0] STEP_SIZE_OFS = 8'h08;
  localparam logic [7:0] STEP_TGT_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h18;
  localparam logic [7:0] IRQ_EN_OFS = 8'h1c;
  localparam logic [7:0] OFFSET_OFS = 8'h20;
  // Control and status field positions
  localparam int unsigned CTRL_MANUAL_BIT = 0;
  localparam int unsigned CTRL_SEL_LSB = 1;
  localparam int unsigned STAT_SEL_LSB = 6;
  // Interrupt field positions
  localparam int unsigned IRQ_LOCK_BIT = 0;
  localparam int unsigned IRQ_REF_LSB = 1;
  localparam int unsigned IRQ_XTAL_BIT = 5;
  localparam int unsigned IRQ_STEP_BIT = 6;
  // Reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [31:0] OUT_EN_RST = 32'hffff_ffff;
  localparam logic [31:0] STEP_SIZE_RST = 32'h0000_0001;
  localparam logic [3:0] STEP_TGT_RST = 4'h0;
  localparam logic [6:0] IRQ_EN_RST = 7'h00;
  // Control pins as seen after synchronising
  typedef struct packed {
    logic out_off;
    logic step_up;
    logic step_down;
    logic [1:0] sel;
  } pin_t;
  // Internal monitor results
  typedef struct packed {
    logic locked;
    logic [3:0] ref_ok;
    logic xtal_ok;
  } monitor_t;
endpackage

// *** dv/pin_host.sv ***
// Board-side host model that drives the control pins
`timescale 1ns/1ps
`default_nettype none
module pin_host (
  input wire logic clk_i,
  output logic out_off_o,
  output logic step_up_o,
  output logic step_down_o,
  output logic [1:0] sel_o
);
  // Idle low, as the on-chip pull-downs leave unused pins
  initial begin
    out_off_o = 1'b0;
    step_up_o = 1'b0;
    step_down_o = 1'b0;
    sel_o = 2'h0;
  end
  // One step request; hold of at least 2 keeps both phases visible to the synchroniser
  task automatic step(input logic up, input int hold);
    @(posedge clk_i);
    if (up) begin
      step_up_o <= 1'b1;
    end else begin
      step_down_o <= 1'b1;
    end
    repeat (hold) @(posedge clk_i);
    step_up_o <= 1'b0;
    step_down_o <= 1'b0;
    repeat (hold) @(posedge clk_i);
  endtask
  // Drive the manual select code of the wanted input
  task automatic pick(input logic [1:0] code);
    @(posedge clk_i);
    sel_o <= code;
  endtask
  // Global output disable level
  task automatic set_off(input logic v);
    @(posedge clk_i);
    out_off_o <= v;
  endtask
endmodule
`default_nettype wire

// *** dv/clock_status_control_pins_tb.sv ***
// Self-checking bench for the clock status and control pin block
`timescale 1ns/1ps
`default_nettype none
module clock_status_control_pins_tb;
  import clock_status_control_pkg::*;
  // Table row: monitor levels, disable pin, expected status pins and enables
  typedef struct packed {
    monitor_t mon;
    logic off;
    logic [5:0] pins;
    logic [9:0] en;
  } row_t;
  localparam row_t ROWS [4] = '{
    '{6'h3f, 1'b0, 6'h3f, 10'h3ff},
    '{6'h14, 1'b1, 6'h14, 10'h000},
    '{6'h2b, 1'b0, 6'h2b, 10'h3ff},
    '{6'h00, 1'b1, 6'h00, 10'h000}
  };
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [3:0] wsel = 4'hf; // Byte lanes for the next access
  logic [31:0] rdat;
  logic ack;
  logic [31:0] rd;
  monitor_t mon = '0; // Internal monitor levels
  logic off_p, up_p, dn_p;
  logic [1:0] sel_p;
  logic [9:0] en;
  logic [9:0][31:0] ofs;
  logic [1:0] act;
  logic lock_n, l0, l1, l2, l3, lx, irq;
  int miscompares = 0;
  int tests_run = 0;
  // Free-running 250 MHz clock
  always #2 clk_i = ~clk_i;
  pin_host host_u (.clk_i(clk_i), .out_off_o(off_p), .step_up_o(up_p),
    .step_down_o(dn_p), .sel_o(sel_p));
  clock_status_control_pins #(.NUM_OUT(10)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .output_disable_n_i(off_p),
    .freq_step_up_i(up_p), .freq_step_down_i(dn_p), .input_select_i(sel_p),
    .pll_locked_i(mon.locked), .ref_clock_present_i(mon.ref_ok),
    .xtal_present_i(mon.xtal_ok), .clk_out_enable_o(en), .freq_offset_o(ofs),
    .active_ref_sel_o(act), .lock_indicator_n_o(lock_n), .input0_signal_loss_n_o(l0),
    .input1_signal_loss_n_o(l1), .input2_signal_loss_n_o(l2),
    .input3_signal_loss_n_o(l3), .xtal_signal_loss_n_o(lx), .irq_o(irq));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Compare one value; four-state equality so an unknown matches only an unknown
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // Classic single Wishbone cycle; request held until ack is sampled
  // No limit of its own: only the watchdog ends a wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= wsel;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // The slave answers one cycle after the taking edge
    check(32'(n), 32'h2);
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog: the whole run needs well under 2000 cycles
  initial begin
    tick(5000);
    miscompares++;
    give_verdict();
  end
  initial begin
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    check(32'(en), 32'h0);
    check(32'(lock_n), 32'h0);
    wb(1'b0, STEP_SIZE_OFS, 32'h0);
    check(rd, 32'h1);
    // Status levels and disable pin from the table
    foreach (ROWS[i]) begin
      mon <= ROWS[i].mon;
      host_u.set_off(ROWS[i].off);
      tick(5);
      check(32'({lock_n, l3, l2, l1, l0, lx}), 32'(ROWS[i].pins));
      check(32'(en), 32'(ROWS[i].en));
    end
    // The table changed lock, lost every reference at least once and lost the crystal
    wb(1'b0, IRQ_STAT_OFS, 32'h0);
    check(rd, 32'h3f);
    wb(1'b1, IRQ_CLR_OFS, 32'h3f);
    // Only lane 1 of a write lands
    wsel = 4'h2;
    wb(1'b1, STEP_SIZE_OFS, 32'hffff_ffff);
    wsel = 4'hf;
    wb(1'b0, STEP_SIZE_OFS, 32'h0);
    check(rd, 32'h0000_ff01);
    // Steps on output 3 with size 5; a long high pulse counts once
    wb(1'b1, STEP_SIZE_OFS, 32'h5);
    wb(1'b1, STEP_TGT_OFS, 32'h3);
    host_u.step(1'b1, 6);
    tick(1);
    check(ofs[3], 32'h5);
    host_u.step(1'b0, 2);
    host_u.step(1'b0, 2);
    tick(1);
    check(ofs[3], 32'hffff_fffb);
    wb(1'b0, OFFSET_OFS, 32'h0);
    check(rd, 32'hffff_fffb);
    // Target beyond the outputs changes nothing
    wb(1'b1, STEP_TGT_OFS, 32'hc);
    host_u.step(1'b1, 2);
    tick(1);
    check(ofs[3], 32'hffff_fffb);
    // Manual pin selection over every code, then software selection
    wb(1'b1, CTRL_OFS, 32'h1);
    for (int c = 0; c < 4; c++) begin
      host_u.pick(2'(c));
      tick(5);
      check(32'(act), 32'(c));
    end
    wb(1'b0, STATUS_OFS, 32'h0);
    check(rd, 32'h0000_00c0);
    wb(1'b1, CTRL_OFS, 32'h4);
    tick(2);
    check(32'(act), 32'h2);
    // Step event raises, mask hides, clear drops the interrupt
    wb(1'b0, IRQ_STAT_OFS, 32'h0);
    check(rd, 32'h40);
    wb(1'b1, IRQ_EN_OFS, 32'h40);
    tick(1);
    check(32'(irq), 32'h1);
    wb(1'b1, IRQ_EN_OFS, 32'h0);
    tick(1);
    check(32'(irq), 32'h0);
    wb(1'b1, IRQ_CLR_OFS, 32'h40);
    wb(1'b1, IRQ_EN_OFS, 32'h40);
    tick(1);
    check(32'(irq), 32'h0);
    // Unmapped address reads zero
    wb(1'b1, 8'h3c, 32'hffff_ffff);
    wb(1'b0, 8'h3c, 32'h0);
    check(rd, 32'h0);
    // Reset in mid-run clears offsets and enables
    rst_i <= 1'b1;
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    check(ofs[3], 32'h0);
    check(32'(en), 32'h0);
    check(32'(irq), 32'h0);
    check(32'(act), 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
